//--- lcd_out_cfg_pkg.sv
// constants, field layouts and types for the lcd output configuration block
// assumes a single 125 MHz system clock and an apb register port
package lcd_out_cfg_pkg;

    // ========================================
    // register byte offsets
    localparam logic [7:0] OFS_PIN_SEL = 8'h00;
    localparam logic [7:0] OFS_GP_LEVEL = 8'h04;
    localparam logic [7:0] OFS_DRIVE = 8'h08;
    localparam logic [7:0] OFS_PWM_WIDTH = 8'h0c;
    localparam logic [7:0] OFS_COMMIT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ========================================
    // field positions
    localparam int POS_CONTRAST = 0;
    localparam int POS_BIAS = 3;
    localparam int POS_DUTY = 4;
    localparam int POS_CLK_SRC = 5;
    localparam int POS_LCD_DIV = 6;
    localparam int POS_PWM_DIV = 9;
    localparam int POS_POWER_SAVE = 12;
    localparam int POS_W2 = 8;
    localparam int POS_W3 = 16;
    localparam int POS_PWM_DIVISOR = 16;
    localparam int POS_PENDING = 31;

    // ========================================
    // divisors in source clock periods
    localparam logic [12:0] LCD_DIV_000 = 13'h1800;
    localparam logic [12:0] LCD_DIV_100 = 13'h1200;
    localparam logic [12:0] LCD_DIV_010 = 13'h0c00;
    localparam logic [12:0] LCD_DIV_110 = 13'h0900;
    localparam logic [12:0] LCD_DIV_001 = 13'h0600;
    localparam logic [10:0] PWM_DIV_BASE = 11'h600;
    localparam logic [10:0] PWM_DIV_STEP = 11'h080;
    localparam int PWM_SLOT_SHIFT = 6;

    // ========================================
    // reset values and internal oscillator rate
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam int RC_TICK_CYCLES = 4;

    typedef enum logic [1:0] {
        FN_SEGMENT,
        FN_GP,
        FN_PWM,
        FN_CLOCK
    } pin_fn_type;

    typedef struct packed {
        logic [11:0] pin_sel;
        logic [7:0] gp_level_bits;
        logic [2:0] contrast_step_code;
        logic bias_select;
        logic duty_select;
        logic clock_source_select;
        logic [2:0] lcd_frame_div_code;
        logic [2:0] pwm_frame_div_code;
        logic power_save_select;
        logic [5:0] w1;
        logic [5:0] w2;
        logic [5:0] w3;
    } cfg_type;

    localparam cfg_type RST_CFG = '0;

endpackage

//--- lcd_out_cfg.sv
// output configuration decode for a multiplexed lcd driver: shared pin
// functions, general-purpose levels, pwm, clock out, drive selections
// assumes an apb master on i_clk_sys; oscillator pin is asynchronous
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module lcd_out_cfg
    import lcd_out_cfg_pkg::*;
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_arst_n, // async reset, low active
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb direction
    input wire logic [7:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    input wire logic [3:0] i_pstrb, // apb byte strobes
    input wire logic i_oscillator_pin, // external clock pin
    output logic o_pready, // apb ready
    output logic [31:0] o_prdata, // apb read data
    output logic o_pslverr, // apb error
    output logic [7:0] o_pin_level, // level of pins 1-8
    output logic [7:0] o_pin_seg, // pin carries segment wave
    output logic [2:0] o_contrast_step, // top bias step count
    output logic o_bias_half, // half bias drive
    output logic o_duty_third, // third duty drive
    output logic o_fourth_common_out_active, // shared pin is common 4
    output logic o_lcd_frame_tick, // lcd frame pulse
    output logic o_pwm_frame_tick, // pwm frame pulse
    output logic o_outputs_grounded, // common/segment at ground
    output logic o_ext_clock_used // external source active
);
    import lcd_out_cfg_pkg::*;

    // ========================================
    // functions
    function automatic pin_fn_type pin_fn(input cfg_type c, input int idx);
        logic [1:0] s;
        s = c.pin_sel[2*idx +: 2];
        if (idx >= 4)
            return c.pin_sel[8 + idx - 4] ? FN_GP : FN_SEGMENT;
        if (s == 2'b01)
            return FN_GP;
        if (s[1] && idx == 3)
            return FN_CLOCK;
        if (s == 2'b10)
            return FN_PWM;
        return FN_SEGMENT;
    endfunction

    function automatic logic [12:0] lcd_div(input logic [2:0] code);
        case (code)
            3'h0: return LCD_DIV_000;
            3'h1: return LCD_DIV_100;
            3'h2: return LCD_DIV_010;
            3'h3: return LCD_DIV_110;
            3'h4: return LCD_DIV_001;
            default: return LCD_DIV_000;
        endcase
    endfunction

    function automatic logic [10:0] pwm_div(input logic [2:0] code);
        return PWM_DIV_BASE - 11'(PWM_DIV_STEP * code);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = wd[8*b +: 8];
        return r;
    endfunction

    // ========================================
    // staged and active configuration
    cfg_type staged;
    cfg_type active;
    logic [31:0] reg_pin_sel;
    logic [31:0] reg_gp;
    logic [31:0] reg_drive;
    logic [31:0] reg_pwm;
    logic acc_wr;
    logic commit_wr;
    logic [12:0] lcd_divisor;
    logic [10:0] pwm_divisor;

    assign acc_wr = i_psel && i_penable && o_pready && i_pwrite;
    assign commit_wr = acc_wr && i_paddr == OFS_COMMIT && i_pstrb[0]
        && i_pwdata[0];
    assign reg_pin_sel = {20'h0, staged.pin_sel};
    assign reg_gp = {24'h0, staged.gp_level_bits};
    assign reg_drive = {19'h0, staged.power_save_select,
        staged.pwm_frame_div_code, staged.lcd_frame_div_code,
        staged.clock_source_select, staged.duty_select,
        staged.bias_select, staged.contrast_step_code};
    assign reg_pwm = {10'h0, staged.w3, 2'h0, staged.w2, 2'h0, staged.w1};
    assign lcd_divisor = lcd_div(active.lcd_frame_div_code);
    assign pwm_divisor = pwm_div(active.pwm_frame_div_code);

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            staged <= RST_CFG;
        end
        else if (acc_wr)
        begin
            logic [31:0] m;
            m = RST_REG;
            case (i_paddr)
                OFS_PIN_SEL:
                begin
                    m = merge(reg_pin_sel, i_pwdata, i_pstrb);
                    staged.pin_sel <= m[11:0];
                end
                OFS_GP_LEVEL:
                begin
                    m = merge(reg_gp, i_pwdata, i_pstrb);
                    staged.gp_level_bits <= m[7:0];
                end
                OFS_DRIVE:
                begin
                    m = merge(reg_drive, i_pwdata, i_pstrb);
                    staged.contrast_step_code <= m[POS_CONTRAST +: 3];
                    staged.bias_select <= m[POS_BIAS];
                    staged.duty_select <= m[POS_DUTY];
                    staged.clock_source_select <= m[POS_CLK_SRC];
                    staged.lcd_frame_div_code <= m[POS_LCD_DIV +: 3];
                    staged.pwm_frame_div_code <= m[POS_PWM_DIV +: 3];
                    staged.power_save_select <= m[POS_POWER_SAVE];
                end
                OFS_PWM_WIDTH:
                begin
                    m = merge(reg_pwm, i_pwdata, i_pstrb);
                    staged.w1 <= m[5:0];
                    staged.w2 <= m[POS_W2 +: 6];
                    staged.w3 <= m[POS_W3 +: 6];
                end
                default:
                begin
                    m = RST_REG;
                end
            endcase
        end
    end

    // bits written earlier only reach the pins together on commit
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            active <= RST_CFG;
        else if (commit_wr)
            active <= staged;
    end

    // ========================================
    // apb answer: one access cycle, no wait states
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pready <= 1'b0;
            o_prdata <= RST_REG;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            o_prdata <= RST_REG;
            if (i_psel && !i_penable)
            begin
                case (i_paddr)
                    OFS_PIN_SEL: o_prdata <= reg_pin_sel;
                    OFS_GP_LEVEL: o_prdata <= reg_gp;
                    OFS_DRIVE: o_prdata <= reg_drive;
                    OFS_PWM_WIDTH: o_prdata <= reg_pwm;
                    OFS_COMMIT: o_prdata <= RST_REG;
                    OFS_STATUS:
                    begin
                        o_prdata[12:0] <= lcd_divisor;
                        o_prdata[POS_PWM_DIVISOR +: 11] <= pwm_divisor;
                        o_prdata[POS_PENDING] <= staged != active;
                    end
                    default: o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ========================================
    // source clock ticks
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic [7:0] rc_cnt;
    logic rc_tick;
    logic src_tick;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= i_oscillator_pin;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // rc model: a fixed tick rate; stops in power save like the oscillator
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rc_cnt <= 8'h00;
        else if (active.power_save_select || rc_tick)
            rc_cnt <= 8'h00;
        else
            rc_cnt <= rc_cnt + 8'h01;
    end

    assign rc_tick = rc_cnt == 8'(RC_TICK_CYCLES - 1);
    assign src_tick = !active.power_save_select &&
        (active.clock_source_select ? osc_sync && !osc_prev : rc_tick);

    // ========================================
    // frame dividers, pwm and clock out
    logic [12:0] lcd_cnt;
    logic [10:0] pwm_cnt;
    logic [2:0] clk_cnt;
    logic [2:0] pwm_hi;
    logic [10:0] slot;

    assign slot = pwm_divisor >> PWM_SLOT_SHIFT;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            lcd_cnt <= 13'h0000;
            pwm_cnt <= 11'h000;
            clk_cnt <= 3'h0;
            o_lcd_frame_tick <= 1'b0;
            o_pwm_frame_tick <= 1'b0;
        end
        else
        begin
            o_lcd_frame_tick <= 1'b0;
            o_pwm_frame_tick <= 1'b0;
            // a new divisor may be below the running count: restart frames
            if (commit_wr)
            begin
                lcd_cnt <= 13'h0000;
                pwm_cnt <= 11'h000;
            end
            else if (src_tick)
            begin
                clk_cnt <= clk_cnt + 3'h1;
                if (lcd_cnt >= lcd_divisor - 13'h0001)
                begin
                    lcd_cnt <= 13'h0000;
                    o_lcd_frame_tick <= 1'b1;
                end
                else
                    lcd_cnt <= lcd_cnt + 13'h0001;
                if (pwm_cnt >= pwm_divisor - 11'h001)
                begin
                    pwm_cnt <= 11'h000;
                    o_pwm_frame_tick <= 1'b1;
                end
                else
                    pwm_cnt <= pwm_cnt + 11'h001;
            end
        end
    end

    // width code plus one slots of the frame, so code 63 is a full period
    assign pwm_hi[0] = pwm_cnt < 11'(({5'h0, active.w1} + 11'h1) * slot);
    assign pwm_hi[1] = pwm_cnt < 11'(({5'h0, active.w2} + 11'h1) * slot);
    assign pwm_hi[2] = pwm_cnt < 11'(({5'h0, active.w3} + 11'h1) * slot);

    // ========================================
    // pin drive and drive selections
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pin_level <= 8'h00;
            o_pin_seg <= 8'hff;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                o_pin_seg[i] <= 1'b0;
                case (pin_fn(active, i))
                    FN_GP: o_pin_level[i] <= active.gp_level_bits[i];
                    FN_PWM: o_pin_level[i] <= pwm_hi[i % 3] &&
                        !active.power_save_select;
                    FN_CLOCK: o_pin_level[i] <= !active.power_save_select &&
                        (active.pin_sel[6] ? clk_cnt[2] : clk_cnt[0]);
                    default:
                    begin
                        o_pin_level[i] <= 1'b0;
                        o_pin_seg[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_contrast_step <= 3'h0;
            o_bias_half <= 1'b0;
            o_duty_third <= 1'b0;
            o_fourth_common_out_active <= 1'b1;
            o_outputs_grounded <= 1'b0;
            o_ext_clock_used <= 1'b0;
        end
        else
        begin
            o_contrast_step <= active.contrast_step_code == 3'h7 ? 3'h0 :
                active.contrast_step_code;
            o_bias_half <= active.bias_select;
            o_duty_third <= active.duty_select;
            o_fourth_common_out_active <= !active.duty_select;
            o_outputs_grounded <= active.power_save_select;
            o_ext_clock_used <= active.clock_source_select;
        end
    end

    // ========================================
    // assertions
    AST_GP_LEVEL: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        active.pin_sel[9] |=> o_pin_level[5] == $past(active.gp_level_bits[5]))
        else $error("gp pin level wrong");
    AST_PIN1_PWM: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        active.pin_sel[1:0] == 2'b10 && !active.power_save_select
        |=> !o_pin_seg[0] && o_pin_level[0] == $past(pwm_hi[0]))
        else $error("pin 1 pwm wrong");
    AST_PIN4_GP: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        active.pin_sel[7:6] == 2'b01
        |=> o_pin_level[3] == $past(active.gp_level_bits[3]))
        else $error("pin 4 gp wrong");
    AST_CLK_DIV8: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        active.pin_sel[7:6] == 2'b11 && !active.power_save_select
        |=> o_pin_level[3] == $past(clk_cnt[2]))
        else $error("pin 4 clock wrong");
    AST_PIN5_SEG: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !active.pin_sel[8] |=> o_pin_seg[4] && !o_pin_level[4])
        else $error("pin 5 not segment");
    AST_CONTRAST: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        active.contrast_step_code == 3'h7 |=> o_contrast_step == 3'h0)
        else $error("contrast fallback wrong");
    AST_DUTY_FOURTH_COMMON_OUT: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_fourth_common_out_active == !o_duty_third)
        else $error("fourth_common_out and duty disagree");
    AST_SAVE_STOP: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        active.power_save_select ##1 active.power_save_select
        |=> !o_lcd_frame_tick && !o_pwm_frame_tick)
        else $error("frame tick in power save");
    AST_LCD_RANGE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $stable(active) |-> lcd_cnt < lcd_divisor)
        else $error("lcd counter out of range");
    AST_COMMIT: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !commit_wr |=> $stable(active))
        else $error("config changed without commit");

endmodule

//--- host_model.sv
// host controller stand-in: apb master tasks and an external clock
// tasks are called right after a rising edge of i_clk_sys
`timescale 1ns/1ps
module host_model
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_pready, // apb ready
    input wire logic [31:0] i_prdata, // apb read data
    input wire logic i_pslverr, // apb error
    input wire logic i_ext_on, // let the external clock run
    output logic o_psel, // apb select
    output logic o_penable, // apb enable
    output logic o_pwrite, // apb direction
    output logic [7:0] o_paddr, // apb address
    output logic [31:0] o_pwdata, // apb write data
    output logic [3:0] o_pstrb, // apb strobes
    output logic o_ext_clk // external clock, low when stopped
);
    logic [2:0] half = 3'h0;

    initial
    begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
        o_pstrb = 4'h0;
        o_ext_clk = 1'b0;
    end

    // ========================================
    // external clock: ten system cycles a period, still when stopped
    always @(posedge i_clk_sys)
    begin
        if (!i_ext_on)
        begin
            half <= 3'h0;
            o_ext_clk <= 1'b0;
        end
        else if (half == 3'h4)
        begin
            half <= 3'h0;
            o_ext_clk <= ~o_ext_clk;
        end
        else
            half <= half + 3'h1;
    end

    // ========================================
    // one transfer; a missing ready is cut short only by the bench timeout
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        o_pstrb <= 4'hf;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        @(posedge i_clk_sys);
        while (i_pready !== 1'b1)
            @(posedge i_clk_sys);
        q = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule

//--- test_lcd_driver_output_config_decode.sv
// self-checking bench for the lcd output configuration decode block
// host_model supplies apb transfers and the external clock
`timescale 1ns/1ps
module test_lcd_driver_output_config_decode;
    import lcd_out_cfg_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ext_on = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ext_clk, er;
    logic [7:0] paddr, lvl, seg;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] step;
    logic bias, duty3, fourth_common_out, lcd_tick, pwm_tick, gnd, ext_used;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    lcd_out_cfg DUT (.i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .i_oscillator_pin(ext_clk),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .o_pin_level(lvl), .o_pin_seg(seg), .o_contrast_step(step),
        .o_bias_half(bias), .o_duty_third(duty3), .o_fourth_common_out_active(fourth_common_out),
        .o_lcd_frame_tick(lcd_tick), .o_pwm_frame_tick(pwm_tick),
        .o_outputs_grounded(gnd), .o_ext_clock_used(ext_used));

    host_model host (.i_clk_sys(clk), .i_pready(pready),
        .i_prdata(prdata), .i_pslverr(pslverr), .i_ext_on(ext_on),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb),
        .o_ext_clk(ext_clk));

    // ========================================
    // reporting
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // whole run is about 53k cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_count++;
            wrap_up();
        end
    end

    // ========================================
    // expectations
    function automatic logic [7:0] seg_of(input logic [11:0] s);
        logic [7:0] m;
        for (int i = 0; i < 3; i++)
            m[i] = (s[2*i] == s[2*i+1]);
        m[3] = (s[7:6] == 2'b00);
        m[7:4] = ~s[11:8];
        return m;
    endfunction

    function automatic logic [7:0] gp_of(input logic [11:0] s);
        logic [7:0] m;
        for (int i = 0; i < 4; i++)
            m[i] = (s[2*i +: 2] == 2'b01);
        m[7:4] = s[11:8];
        return m;
    endfunction

    function automatic logic [12:0] lcd_div(input logic [2:0] c);
        case (c)
            3'h1: return 13'h1200;
            3'h2: return 13'h0c00;
            3'h3: return 13'h0900;
            3'h4: return 13'h0600;
            default: return 13'h1800;
        endcase
    endfunction

    // ========================================
    // bus helpers and measurements
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic commit;
        wr(OFS_COMMIT, 32'h1);
        repeat (2) @(posedge clk);
    endtask

    task automatic check_cfg(input logic [11:0] s, input logic [7:0] g,
        input logic [12:0] d);
        logic [7:0] m;
        m = gp_of(s);
        chk(seg === seg_of(s), "pin function");
        chk((lvl & m) === (g & m), "gp level");
        chk(step === ((d[2:0] == 3'h7) ? 3'h0 : d[2:0]), "contrast");
        chk(bias === d[3], "bias");
        chk(duty3 === d[4] && fourth_common_out === ~d[4], "duty");
        chk(ext_used === d[5], "clock source");
        chk(gnd === d[12], "power save");
        host.xfer(1'b0, OFS_STATUS, 32'h0, rd, er);
        chk(rd[12:0] === lcd_div(d[8:6]), "lcd divisor");
        chk(rd[26:16] === 11'h600 - {1'b0, d[11:9], 7'h0}, "pwm div");
        chk(rd[31] === 1'b0, "pending after commit");
    endtask

    // cycles between two frame pulses
    task automatic gap(input bit lcd, output int n);
        int w;
        w = 0;
        while ((lcd ? lcd_tick : pwm_tick) !== 1'b1 && w < 40000)
        begin
            @(posedge clk);
            w++;
        end
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((lcd ? lcd_tick : pwm_tick) !== 1'b1 && n < 40000);
    endtask

    // ========================================
    // main sequence
    initial
    begin
        logic [11:0] s, ps;
        logic [7:0] g, pg;
        logic [12:0] d, pd;
        logic [17:0] w, pw;
        logic prev;
        int n, hi;
        int wc[3] = '{0, 37, 63};
        void'($urandom(63));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(seg === 8'hff && fourth_common_out === 1'b1 && lvl === 8'h00, "reset");
        host.xfer(1'b0, 8'h40, 32'h0, rd, er);
        chk(er === 1'b1 && rd === 32'h0, "unmapped read");
        ps = 12'h0;
        pg = 8'h0;
        pd = 13'h0;
        pw = 18'h0;
        for (int i = 0; i < 24; i++)
        begin
            s = 12'($urandom);
            g = 8'($urandom);
            d = 13'($urandom);
            w = 18'($urandom);
            // first passes use the undocumented codes
            if (i < 3)
            begin
                s[2*i +: 2] = 2'b11;
                d[2:0] = 3'h7;
                d[8:6] = 3'(5 + i);
            end
            wr(OFS_PIN_SEL, {20'h0, s});
            wr(OFS_GP_LEVEL, {24'h0, g});
            wr(OFS_DRIVE, {19'h0, d});
            wr(OFS_PWM_WIDTH, {10'h0, w[17:12], 2'h0, w[11:6], 2'h0, w[5:0]});
            host.xfer(1'b0, OFS_STATUS, 32'h0, rd, er);
            chk(rd[31] === ({s, g, d, w} != {ps, pg, pd, pw}), "pend");
            chk(seg === seg_of(ps), "early update");
            commit();
            check_cfg(s, g, d);
            ps = s;
            pg = g;
            pd = d;
            pw = w;
        end
        // pin 1 as pwm on the shortest pwm frame
        foreach (wc[k])
        begin
            wr(OFS_PIN_SEL, 32'h2);
            wr(OFS_PWM_WIDTH, 32'(wc[k]));
            wr(OFS_DRIVE, 32'he00);
            commit();
            gap(1'b0, n);
            chk(n == 640 * RC_TICK_CYCLES, "pwm frame");
            hi = 0;
            repeat (640 * RC_TICK_CYCLES)
            begin
                @(posedge clk);
                hi += (lvl[0] === 1'b1);
            end
            chk(hi == (wc[k] + 1) * 10 * RC_TICK_CYCLES, "pwm width");
        end
        // pin 4 clock out, both ratios
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_PIN_SEL, k ? 32'hc0 : 32'h80);
            commit();
            n = 0;
            prev = lvl[3];
            repeat (640)
            begin
                @(posedge clk);
                n += (lvl[3] === 1'b1 && prev === 1'b0);
                prev = lvl[3];
            end
            hi = 640 / (RC_TICK_CYCLES * (k ? 8 : 2));
            chk(n >= hi - 1 && n <= hi + 1, "clock out");
        end
        wr(OFS_DRIVE, 32'h100);
        commit();
        gap(1'b1, n);
        chk(n == 1536 * RC_TICK_CYCLES, "lcd frame");
        // external clock: one source tick every ten system cycles
        ext_on <= 1'b1;
        wr(OFS_DRIVE, 32'he20);
        commit();
        gap(1'b0, n);
        chk(n == 6400, "external source");
        ext_on <= 1'b0;
        // power save with pwm, gp and clock pins
        wr(OFS_PIN_SEL, 32'h86);
        wr(OFS_GP_LEVEL, 32'h2);
        wr(OFS_PWM_WIDTH, 32'h3f);
        wr(OFS_DRIVE, 32'h1e00);
        commit();
        chk(gnd === 1'b1, "grounded");
        n = 0;
        repeat (3000)
        begin
            @(posedge clk);
            n += (pwm_tick !== 1'b0 || lvl[0] !== 1'b0 || lvl[3] !== 1'b0);
            n += (lvl[1] !== 1'b1);
        end
        chk(n == 0, "power save pins");
        wrap_up();
    end
endmodule
